/* File: shared/e1sa_pkg.sv */
// Constants and types for the E1 automatic A/Sa alarm insertion block
// How it works
// - Power-loss enable with power lost sends A=0, Sa5=1, Sa6=1000.
// - The power-loss pin high means power is lost, low means power is good.
// - Combined enable with power lost plus signal or alignment loss sends A=1, Sa5=1, Sa6=1000.
// - Auxiliary enable with signal loss replaces Sa5 and Sa6 with 10101010.
// - First LOS/LFA enable sends Sa5=1, Sa6=0000 and leaves A at its normal source.
// - First LOS-only enable with signal loss sends A=1, Sa5=1, Sa6=1110.
// - Second LOS/LFA enable sends A=1, Sa5=0, Sa6=0000.
// - Third LOS/LFA enable sends A=0, Sa5=1, Sa6=1100.
// - Fourth LOS/LFA enable sends A=0, Sa5=1, Sa6=1110.
// - First AIS enable with AIS received sends A=1, Sa5=1, Sa6 all ones.
// - Second AIS enable with AIS received sends A=0, Sa5=1, Sa6 all ones.
`default_nettype none
package e1sa_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] E1SA_IDX_CTRL1 = 10'h131;
  localparam logic [9:0] E1SA_IDX_CTRL2 = 10'h132;
  localparam logic [9:0] E1SA_IDX_STAT = 10'h13F;
  localparam logic [7:0] E1SA_CTRL1_RST = 8'h00;
  localparam logic [7:0] E1SA_CTRL2_RST = 8'h00;
  // Control 1 bit positions
  localparam int E1SA_B1_LOSLFA1 = 7;
  localparam int E1SA_B1_LOS1 = 6;
  localparam int E1SA_B1_LOSLFA2 = 5;
  localparam int E1SA_B1_LOSLFA3 = 4;
  localparam int E1SA_B1_LOSLFA4 = 3;
  localparam int E1SA_B1_PWR = 2;
  localparam int E1SA_B1_PWRSIG = 1;
  localparam int E1SA_B1_AUX = 0;
  // Control 2 bit positions; other bits are kept as plain storage
  localparam int E1SA_B2_AIS1 = 7;
  localparam int E1SA_B2_AIS2 = 6;
  // Per-multiframe codes: Sa5 holds 8 bits, Sa6 holds two repeated nibbles
  localparam logic [7:0] E1SA_ONES = 8'hFF;
  localparam logic [7:0] E1SA_ZEROS = 8'h00;
  localparam logic [7:0] E1SA_SA6_1000 = 8'h88;
  localparam logic [7:0] E1SA_SA6_1110 = 8'hEE;
  localparam logic [7:0] E1SA_SA6_1100 = 8'hCC;
  localparam logic [7:0] E1SA_AUX = 8'hAA;
  // Selected source codes, reported in status
  typedef enum logic [3:0] {
    E1SA_SRC_NORMAL = 4'h0,
    E1SA_SRC_PWRSIG = 4'h1,
    E1SA_SRC_PWR = 4'h2,
    E1SA_SRC_AIS1 = 4'h3,
    E1SA_SRC_AIS2 = 4'h4,
    E1SA_SRC_AUX = 4'h5,
    E1SA_SRC_LOS1 = 4'h6,
    E1SA_SRC_LOSLFA1 = 4'h7,
    E1SA_SRC_LOSLFA2 = 4'h8,
    E1SA_SRC_LOSLFA3 = 4'h9,
    E1SA_SRC_LOSLFA4 = 4'hA
  } e1sa_src_t;
  typedef struct packed {
    logic a;
    logic [7:0] sa5;
    logic [7:0] sa6;
  } e1sa_ovh_t;
  typedef struct packed {
    logic sig_loss;
    logic align_loss;
    logic ais;
    logic power_loss;
  } e1sa_cond_t;
endpackage
`default_nettype wire

/* File: rtl/e1sa_insert.sv */
// E1 automatic A/Sa5/Sa6 alarm insertion with APB control registers
//
// The address map and the APB interface to the registers were decided locally.
`default_nettype none
module e1sa_insert (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sig_loss,
  input wire logic align_loss,
  input wire logic ais_rx,
  input wire logic power_loss_pin,
  input wire logic mf_start,
  input wire e1sa_pkg::e1sa_ovh_t norm_ovh,
  output e1sa_pkg::e1sa_ovh_t tx_ovh,
  output logic subst_active
);
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl1_next;
  logic [7:0] ctrl2_reg;
  logic [7:0] ctrl2_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  e1sa_pkg::e1sa_ovh_t ovh_reg;
  e1sa_pkg::e1sa_ovh_t ovh_next;
  e1sa_pkg::e1sa_src_t src_reg;
  e1sa_pkg::e1sa_src_t src_next;
  logic subst_reg;
  logic subst_next;
  e1sa_pkg::e1sa_src_t sel_src;
  e1sa_pkg::e1sa_ovh_t sel_ovh;
  e1sa_pkg::e1sa_cond_t cond;
  logic sig_or_align;
  logic setup_ph;
  logic wr_take;
  logic [9:0] idx;
  logic idx_ok;
  logic [31:0] rd_val;

  assign idx = paddr[11:2];
  assign setup_ph = psel && !penable;
  assign wr_take = psel && penable && pready_reg && pwrite;

  // Pin high reports loss of power
  assign cond.power_loss = power_loss_pin;
  assign cond.sig_loss = sig_loss;
  assign cond.align_loss = align_loss;
  assign cond.ais = ais_rx;
  assign sig_or_align = cond.sig_loss || cond.align_loss;

  // Address decode and read mux
  always_comb
  begin
    idx_ok = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr[1:0] != 2'h0)
    begin
      idx_ok = 1'b0;
    end
    else if (idx == e1sa_pkg::E1SA_IDX_CTRL1)
    begin
      rd_val = {24'h00_0000, ctrl1_reg};
    end
    else if (idx == e1sa_pkg::E1SA_IDX_CTRL2)
    begin
      rd_val = {24'h00_0000, ctrl2_reg};
    end
    else if (idx == e1sa_pkg::E1SA_IDX_STAT)
    begin
      rd_val = {23'h00_0000, subst_active, src_reg, cond};
    end
    else
    begin
      idx_ok = 1'b0;
    end
  end

  // APB: answer is registered in the setup cycle, so every access is one wait-free cycle
  always_comb
  begin
    pready_next = setup_ph;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (setup_ph)
    begin
      pslverr_next = !idx_ok || (pwrite && idx == e1sa_pkg::E1SA_IDX_STAT);
      prdata_next = (pwrite || !idx_ok) ? 32'h0000_0000 : rd_val;
    end
  end

  always_comb
  begin
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    if (wr_take && idx_ok && idx == e1sa_pkg::E1SA_IDX_CTRL1)
    begin
      ctrl1_next = pwdata[7:0];
    end
    if (wr_take && idx_ok && idx == e1sa_pkg::E1SA_IDX_CTRL2)
    begin
      ctrl2_next = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1_reg <= e1sa_pkg::E1SA_CTRL1_RST;
      ctrl2_reg <= e1sa_pkg::E1SA_CTRL2_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Fixed priority: power conditions first, then AIS, then signal-loss codes.
  // Power-and-LOS/LFA beats power alone, since it carries more information.
  always_comb
  begin
    sel_src = e1sa_pkg::E1SA_SRC_NORMAL;
    sel_ovh = norm_ovh;
    if (ctrl1_reg[e1sa_pkg::E1SA_B1_PWRSIG] && cond.power_loss && sig_or_align)
    begin
      sel_src = e1sa_pkg::E1SA_SRC_PWRSIG;
      sel_ovh = '{1'b1, e1sa_pkg::E1SA_ONES, e1sa_pkg::E1SA_SA6_1000};
    end
    else if (ctrl1_reg[e1sa_pkg::E1SA_B1_PWR] && cond.power_loss)
    begin
      sel_src = e1sa_pkg::E1SA_SRC_PWR;
      sel_ovh = '{1'b0, e1sa_pkg::E1SA_ONES, e1sa_pkg::E1SA_SA6_1000};
    end
    else if (ctrl2_reg[e1sa_pkg::E1SA_B2_AIS1] && cond.ais)
    begin
      sel_src = e1sa_pkg::E1SA_SRC_AIS1;
      sel_ovh = '{1'b1, e1sa_pkg::E1SA_ONES, e1sa_pkg::E1SA_ONES};
    end
    else if (ctrl2_reg[e1sa_pkg::E1SA_B2_AIS2] && cond.ais)
    begin
      sel_src = e1sa_pkg::E1SA_SRC_AIS2;
      sel_ovh = '{1'b0, e1sa_pkg::E1SA_ONES, e1sa_pkg::E1SA_ONES};
    end
    else if (ctrl1_reg[e1sa_pkg::E1SA_B1_AUX] && cond.sig_loss)
    begin
      sel_src = e1sa_pkg::E1SA_SRC_AUX;
      sel_ovh = '{norm_ovh.a, e1sa_pkg::E1SA_AUX, e1sa_pkg::E1SA_AUX};
    end
    else if (ctrl1_reg[e1sa_pkg::E1SA_B1_LOS1] && cond.sig_loss)
    begin
      sel_src = e1sa_pkg::E1SA_SRC_LOS1;
      sel_ovh = '{1'b1, e1sa_pkg::E1SA_ONES, e1sa_pkg::E1SA_SA6_1110};
    end
    else if (ctrl1_reg[e1sa_pkg::E1SA_B1_LOSLFA1] && sig_or_align)
    begin
      sel_src = e1sa_pkg::E1SA_SRC_LOSLFA1;
      sel_ovh = '{norm_ovh.a, e1sa_pkg::E1SA_ONES, e1sa_pkg::E1SA_ZEROS};
    end
    else if (ctrl1_reg[e1sa_pkg::E1SA_B1_LOSLFA2] && sig_or_align)
    begin
      sel_src = e1sa_pkg::E1SA_SRC_LOSLFA2;
      sel_ovh = '{1'b1, e1sa_pkg::E1SA_ZEROS, e1sa_pkg::E1SA_ZEROS};
    end
    else if (ctrl1_reg[e1sa_pkg::E1SA_B1_LOSLFA3] && sig_or_align)
    begin
      sel_src = e1sa_pkg::E1SA_SRC_LOSLFA3;
      sel_ovh = '{1'b0, e1sa_pkg::E1SA_ONES, e1sa_pkg::E1SA_SA6_1100};
    end
    else if (ctrl1_reg[e1sa_pkg::E1SA_B1_LOSLFA4] && sig_or_align)
    begin
      sel_src = e1sa_pkg::E1SA_SRC_LOSLFA4;
      sel_ovh = '{1'b0, e1sa_pkg::E1SA_ONES, e1sa_pkg::E1SA_SA6_1110};
    end
  end

  // Code is only swapped at a multiframe boundary so the far end never sees a torn code
  always_comb
  begin
    ovh_next = ovh_reg;
    src_next = src_reg;
    if (mf_start)
    begin
      ovh_next = sel_ovh;
      src_next = sel_src;
    end
    // Flag registered beside the source so the pin comes straight from a flop
    subst_next = (src_next != e1sa_pkg::E1SA_SRC_NORMAL);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovh_reg <= '{1'b0, e1sa_pkg::E1SA_ONES, e1sa_pkg::E1SA_ONES};
      src_reg <= e1sa_pkg::E1SA_SRC_NORMAL;
      subst_reg <= 1'b0;
    end
    else
    begin
      ovh_reg <= ovh_next;
      src_reg <= src_next;
      subst_reg <= subst_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_ovh = ovh_reg;
  assign subst_active = subst_reg;
endmodule
`default_nettype wire

/* File: sim/e1sa_insert_chk_sva.sv */
// Assertion checker for the E1 alarm insertion block
`default_nettype none
module e1sa_insert_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sig_loss,
  input wire logic align_loss,
  input wire logic ais_rx,
  input wire logic power_loss_pin,
  input wire logic mf_start,
  input wire e1sa_pkg::e1sa_ovh_t norm_ovh,
  input wire e1sa_pkg::e1sa_ovh_t tx_ovh,
  input wire logic subst_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("ready late");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
  // Codes may only move at a multiframe boundary
  a_ovh_hold: assert property (!mf_start |=> $stable(tx_ovh)) else $error("code moved");
  a_quiet_passes: assert property (mf_start && !(sig_loss || align_loss || ais_rx || power_loss_pin)
    |=> tx_ovh == $past(norm_ovh) && !subst_active) else $error("normal code lost");
  a_pwr_pin_low: assert property (mf_start && !power_loss_pin
    |=> !(subst_active && tx_ovh.sa6 == 8'h88)) else $error("power code without pin");
  a_pwr_sa5: assert property (subst_active && tx_ovh.sa6 == 8'h88
    |-> tx_ovh.sa5 == 8'hFF) else $error("power code Sa5");
  a_ais_code: assert property (mf_start && ais_rx && !power_loss_pin && !sig_loss && !align_loss
    |=> !subst_active || (tx_ovh.sa5 == 8'hFF && tx_ovh.sa6 == 8'hFF)) else $error("ais code");
  a_aux_needs_los: assert property (mf_start && !sig_loss
    |=> !(subst_active && tx_ovh.sa5 == 8'hAA)) else $error("aux without loss");
endmodule
bind e1sa_insert e1sa_insert_chk i_e1sa_insert_chk (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .sig_loss, .align_loss, .ais_rx, .power_loss_pin, .mf_start, .norm_ovh, .tx_ovh,
  .subst_active);
`default_nettype wire

/* File: sim/e1sa_remote_term.sv */
// Remote terminal model that latches the overhead sent each multiframe
`default_nettype none
module e1sa_remote_term (
  input wire logic pclk,
  input wire logic mf_start,
  input wire e1sa_pkg::e1sa_ovh_t line_ovh,
  output e1sa_pkg::e1sa_ovh_t rx_ovh
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mf_seen;
  // Latch one cycle late, once the new code stands on the line
  always @(posedge pclk)
  begin
    mf_seen <= mf_start;
    if (mf_seen)
      rx_ovh <= line_ovh;
  end
endmodule
`default_nettype wire

/* File: sim/e1sa_insert_tb.sv */
// Self-checking bench for the E1 alarm insertion block
`default_nettype none
module e1sa_insert_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] c1; logic [7:0] c2; logic [3:0] cd; logic [17:0] x;} e1sa_row_t;
  // Conditions: sig, align, ais, power; expected: subst flag then A, Sa5, Sa6
  e1sa_row_t rows [14] = '{'{8'h04, 8'h00, 4'h1, 18'h2FF88}, '{8'h02, 8'h00, 4'h9, 18'h3FF88},
    '{8'h02, 8'h00, 4'h5, 18'h3FF88}, '{8'h01, 8'h00, 4'h8, 18'h3AAAA},
    '{8'h80, 8'h00, 4'h4, 18'h3FF00}, '{8'h40, 8'h00, 4'h8, 18'h3FFEE},
    '{8'h20, 8'h00, 4'h4, 18'h30000}, '{8'h10, 8'h00, 4'h8, 18'h2FFCC},
    '{8'h08, 8'h00, 4'h4, 18'h2FFEE}, '{8'h00, 8'h80, 4'h2, 18'h3FFFF},
    '{8'h00, 8'h40, 4'h2, 18'h2FFFF}, '{8'h04, 8'h00, 4'h0, 18'h15A3C},
    '{8'hFF, 8'hC0, 4'hF, 18'h3FF88}, '{8'h40, 8'h00, 4'h4, 18'h15A3C}};
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic mf_start = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] cd = 4'h0;
  e1sa_pkg::e1sa_ovh_t norm = 17'h15A3C;
  logic [31:0] prdata, rd;
  logic pready, pslverr, subst_active, er;
  e1sa_pkg::e1sa_ovh_t tx_ovh, rx_ovh;
  int err_total = 0;
  int samples_checked = 0;
  e1sa_insert i_e1sa_insert (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sig_loss(cd[3]), .align_loss(cd[2]), .ais_rx(cd[1]),
    .power_loss_pin(cd[0]), .mf_start, .norm_ovh(norm), .tx_ovh, .subst_active);
  e1sa_remote_term i_e1sa_remote_term (.pclk, .mf_start, .line_ovh(tx_ovh), .rx_ovh);
  always #50 pclk = ~pclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x)
    begin
      $display("Error %0t: got %h, expected %h", $time, g, x);
      err_total++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50)
    begin
      $display("Error %0t: no ready", $time);
      err_total++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // Conditions are set together with the boundary pulse
  task automatic mf(input logic [3:0] c);
    cd <= c;
    mf_start <= 1'h1;
    @(posedge pclk);
    mf_start <= 1'h0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (rows[i])
    begin
      apb(1'h1, 12'h4C4, {24'h0, rows[i].c1});
      apb(1'h1, 12'h4C8, {24'h0, rows[i].c2});
      mf(rows[i].cd);
      chk({14'h0, subst_active, rx_ovh}, {14'h0, rows[i].x});
      $display("Row %0d done", i);
    end
    apb(1'h1, 12'h4C4, 32'hFFFFFF04);
    apb(1'h0, 12'h4C4, 32'h0);
    chk(rd, 32'h00000004);
    apb(1'h0, 12'h400, 32'h0);
    chk({rd[30:0], er}, 32'h00000001);
    apb(1'h1, 12'h4FC, 32'h000000FF);
    chk({31'h0, er}, 32'h00000001);
    $display("Register access done");
    // Cause clears between boundaries: code must hold until the next one
    mf(4'h1);
    cd <= 4'h0;
    repeat (3) @(posedge pclk);
    chk({15'h0, tx_ovh}, 32'h0000FF88);
    mf(4'h0);
    chk({14'h0, subst_active, rx_ovh}, 32'h00015A3C);
    $display("Release done");
    // A must follow the normal source when it is low too
    apb(1'h1, 12'h4C4, 32'h00000080);
    norm <= 17'h05A3C;
    mf(4'h4);
    chk({14'h0, subst_active, rx_ovh}, 32'h0002FF00);
    norm <= 17'h15A3C;
    apb(1'h1, 12'h4C4, 32'h00000004);
    $display("Pass-through A done");
    mf(4'h1);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk({14'h0, subst_active, tx_ovh}, 32'h0000FFFF);
    apb(1'h0, 12'h4C4, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h4C8, 32'h0);
    chk(rd, 32'h0);
    $display("Reset done");
    end_sim;
  end
  initial
  begin
    #1000000;
    err_total++;
    end_sim;
  end
endmodule
`default_nettype wire
